// File: supervisor_watchdog_reset.sv
// Supervisor: stretched reset, independent watchdog and power-fail warning
//
// How it works
// - A trigger drives the reset output low for a 200 ms pulse, then releases it.
// - Reset stays low for as long as the supply-low indication is present.
// - After supply-low clears or manual reset rises, reset stays low another 200 ms.
// - Pulling the manual reset input low starts a reset pulse.
// - A watchdog timeout never asserts reset by itself; only external wiring does that.
// - A strobe held at one level for 1.6 s expires the timer and drives timeout low.
// - The watchdog is disabled while the strobe input is undriven.
// - The timer clears on reset asserted, strobe undriven, or any strobe edge.
// - Once low after expiry, the timeout output stays low until the timer clears.
// - The timeout output is low whenever supply-low is indicated.
// - The timeout output has no stretch and rises as soon as supply-low clears.
// - The power-fail warning is low while the comparator says the input is below 1.25 V.
// - The reset stretch lies between 120 ms and 280 ms, 200 ms nominal.
// - The watchdog timeout lies between 1.0 s and 2.25 s, 1.6 s nominal.
`timescale 1ns/10ps
`include "supervisor_watchdog_reset_defines.svh"

module supervisor_watchdog_reset
    import supervisor_watchdog_reset_pkg::*;
#(
    parameter int RST_PULSE_CYC = `SWR_RST_PULSE_CYC,
    parameter int WD_TIMEOUT_CYC = `SWR_WD_TIMEOUT_CYC
) (
    input wire logic i_ref_clk,
    input wire logic i_sys_rst,
    input wire logic i_manual_reset_n,
    input wire logic i_supply_low,
    input wire logic i_watchdog_strobe_in,
    input wire logic i_watchdog_strobe_hiz,
    input wire logic i_power_fail_sense_in,
    output logic o_reset_n,
    output logic o_watchdog_timeout_n,
    output logic o_power_fail_warn_n
);
    localparam int RW = $clog2(RST_PULSE_CYC + 1);
    localparam int WW = $clog2(WD_TIMEOUT_CYC + 1);
    localparam logic [RW-1:0] RST_LAST = RW'(RST_PULSE_CYC - 1);
    localparam logic [WW-1:0] WD_LAST = WW'(WD_TIMEOUT_CYC - 1);

    // ----------------------------------------
    // Reset generator
    // ----------------------------------------
    rst_state_e rst_state_r, rst_state_nxt;
    logic [RW-1:0] rst_cnt_r, rst_cnt_nxt;
    logic reset_n_r, reset_n_nxt;
    logic hold_cause;

    // Either cause holds reset; the stretch restarts when both are gone
    assign hold_cause = i_supply_low | ~i_manual_reset_n;

    // Next-state for the reset pulse
    always_comb begin
        rst_state_nxt = rst_state_r;
        rst_cnt_nxt = rst_cnt_r;
        case (rst_state_r)
            RST_IDLE: begin
                if (hold_cause) begin
                    rst_state_nxt = RST_HOLD;
                end
            end
            RST_HOLD: begin
                if (!hold_cause) begin
                    rst_state_nxt = RST_STRETCH;
                    rst_cnt_nxt = '0;
                end
            end
            RST_STRETCH: begin
                if (hold_cause) begin
                    rst_state_nxt = RST_HOLD;
                end else if (rst_cnt_r == RST_LAST) begin
                    rst_state_nxt = RST_IDLE;
                end else begin
                    rst_cnt_nxt = rst_cnt_r + 1'b1;
                end
            end
            default: begin
                rst_state_nxt = RST_HOLD;
            end
        endcase
        reset_n_nxt = (rst_state_nxt == RST_IDLE);
    end

    // Power-on starts in a held reset so the processor gets a full pulse
    always_ff @(posedge i_ref_clk) begin
        if (i_sys_rst) begin
            rst_state_r <= RST_HOLD;
            rst_cnt_r <= '0;
            reset_n_r <= 1'b0;
        end else begin
            rst_state_r <= rst_state_nxt;
            rst_cnt_r <= rst_cnt_nxt;
            reset_n_r <= reset_n_nxt;
        end
    end

    // ----------------------------------------
    // Watchdog
    // ----------------------------------------
    logic [WW-1:0] wd_cnt_r, wd_cnt_nxt;
    logic strobe_d_r, strobe_d_nxt;
    logic expired_r, expired_nxt;
    logic wdo_n_r, wdo_n_nxt;
    logic wd_clear;

    // Timer and expiry flag
    always_comb begin
        strobe_d_nxt = i_watchdog_strobe_in;
        wd_clear = ~reset_n_r | i_watchdog_strobe_hiz | (i_watchdog_strobe_in != strobe_d_r);
        wd_cnt_nxt = wd_cnt_r;
        expired_nxt = expired_r;
        if (wd_clear) begin
            wd_cnt_nxt = '0;
            expired_nxt = 1'b0;
        end else if (!expired_r) begin
            if (wd_cnt_r == WD_LAST) begin
                expired_nxt = 1'b1;
            end else begin
                wd_cnt_nxt = wd_cnt_r + 1'b1;
            end
        end
        wdo_n_nxt = ~(expired_nxt | i_supply_low);
    end

    // Registering the watchdog state
    always_ff @(posedge i_ref_clk) begin
        if (i_sys_rst) begin
            wd_cnt_r <= '0;
            strobe_d_r <= 1'b0;
            expired_r <= 1'b0;
            wdo_n_r <= 1'b1;
        end else begin
            wd_cnt_r <= wd_cnt_nxt;
            strobe_d_r <= strobe_d_nxt;
            expired_r <= expired_nxt;
            wdo_n_r <= wdo_n_nxt;
        end
    end

    // ----------------------------------------
    // Power-fail warning
    // ----------------------------------------
    logic pfo_n_r, pfo_n_nxt;

    always_comb begin
        pfo_n_nxt = ~i_power_fail_sense_in;
    end

    // One register keeps the output glitch free
    always_ff @(posedge i_ref_clk) begin
        if (i_sys_rst) begin
            pfo_n_r <= 1'b1;
        end else begin
            pfo_n_r <= pfo_n_nxt;
        end
    end

    assign o_reset_n = reset_n_r;
    assign o_watchdog_timeout_n = wdo_n_r;
    assign o_power_fail_warn_n = pfo_n_r;

    // ----------------------------------------
    // Assertions
    // ----------------------------------------
    property p_supply_holds_reset;
        @(posedge i_ref_clk) disable iff (i_sys_rst)
        i_supply_low |=> !o_reset_n;
    endproperty
    a_supply_holds_reset: assert property (p_supply_holds_reset)
        else $error("reset released during supply low");

    property p_stretch_low;
        @(posedge i_ref_clk) disable iff (i_sys_rst)
        $fell(hold_cause) |=> !o_reset_n [*8];
    endproperty
    a_stretch_low: assert property (p_stretch_low)
        else $error("reset not stretched after cause");

    property p_stretch_len;
        @(posedge i_ref_clk) disable iff (i_sys_rst)
        $rose(o_reset_n) |-> rst_cnt_r == RST_LAST;
    endproperty
    a_stretch_len: assert property (p_stretch_len)
        else $error("reset pulse wrong length");

    property p_manual_trigger;
        @(posedge i_ref_clk) disable iff (i_sys_rst)
        !i_manual_reset_n |=> !o_reset_n;
    endproperty
    a_manual_trigger: assert property (p_manual_trigger)
        else $error("manual reset ignored");

    property p_wd_no_reset;
        @(posedge i_ref_clk) disable iff (i_sys_rst)
        (o_reset_n && !hold_cause) |=> o_reset_n;
    endproperty
    a_wd_no_reset: assert property (p_wd_no_reset)
        else $error("reset without cause");

    property p_expire_out;
        @(posedge i_ref_clk) disable iff (i_sys_rst)
        $rose(expired_r) |-> !o_watchdog_timeout_n;
    endproperty
    a_expire_out: assert property (p_expire_out)
        else $error("timeout output not low on expiry");

    property p_hiz_clear;
        @(posedge i_ref_clk) disable iff (i_sys_rst)
        i_watchdog_strobe_hiz |=> (wd_cnt_r == '0) && !expired_r;
    endproperty
    a_hiz_clear: assert property (p_hiz_clear)
        else $error("watchdog runs while strobe undriven");

    property p_edge_clear;
        @(posedge i_ref_clk) disable iff (i_sys_rst)
        (i_watchdog_strobe_in != strobe_d_r) |=> wd_cnt_r == '0;
    endproperty
    a_edge_clear: assert property (p_edge_clear)
        else $error("strobe edge did not clear timer");

    property p_wdo_sticky;
        @(posedge i_ref_clk) disable iff (i_sys_rst)
        (expired_r && !wd_clear) |=> !o_watchdog_timeout_n;
    endproperty
    a_wdo_sticky: assert property (p_wdo_sticky)
        else $error("timeout output rose before clear");

    property p_wdo_supply;
        @(posedge i_ref_clk) disable iff (i_sys_rst)
        i_supply_low |=> !o_watchdog_timeout_n;
    endproperty
    a_wdo_supply: assert property (p_wdo_supply)
        else $error("timeout output high in supply low");

    property p_wdo_release;
        @(posedge i_ref_clk) disable iff (i_sys_rst)
        (!i_supply_low && !expired_nxt) |=> o_watchdog_timeout_n;
    endproperty
    a_wdo_release: assert property (p_wdo_release)
        else $error("timeout output stretched");

    property p_pfo;
        @(posedge i_ref_clk) disable iff (i_sys_rst)
        ##1 (o_power_fail_warn_n == !$past(i_power_fail_sense_in));
    endproperty
    a_pfo: assert property (p_pfo)
        else $error("power-fail warning wrong");
endmodule

// File: supervisor_watchdog_reset_defines.svh
// Timing constants for the supervisor watchdog and reset block
`ifndef SUPERVISOR_WATCHDOG_RESET_DEFINES_SVH
`define SUPERVISOR_WATCHDOG_RESET_DEFINES_SVH

// ----------------------------------------
// Clock and timing
// ----------------------------------------
`define SWR_CLK_HZ 10000000
// Reset stretch, in milliseconds (nominal, inside 120..280)
`define SWR_RST_PULSE_MS 200
// Watchdog timeout, in tenths of a second (nominal 1.6 s, inside 1.0..2.25)
`define SWR_WD_TIMEOUT_DS 16
`define SWR_RST_PULSE_CYC ((`SWR_CLK_HZ / 1000) * `SWR_RST_PULSE_MS)
`define SWR_WD_TIMEOUT_CYC ((`SWR_CLK_HZ / 10) * `SWR_WD_TIMEOUT_DS)

`endif

// File: supervisor_watchdog_reset_pkg.sv
// Types for the supervisor watchdog and reset block
package supervisor_watchdog_reset_pkg;
    // Reset generator states
    typedef enum logic [1:0] {
        RST_IDLE,
        RST_HOLD,
        RST_STRETCH
    } rst_state_e;
endpackage

// File: host_cpu_model.sv
// Behavioural model of the supervised processor that drives the watchdog strobe
`timescale 1ns/10ps

module host_cpu_model #(
    parameter int PERIOD = 10
) (
    input wire logic i_ref_clk,
    input wire logic i_kick_en,
    input wire logic i_strobe_free,
    output logic o_strobe,
    output logic o_strobe_hiz
);
    int cnt;
    logic kick_q, free_q;

    // ----------------------------------------
    // Strobe driver
    // ----------------------------------------
    initial begin
        cnt = 0;
        kick_q = 1'b0;
        free_q = 1'b0;
        o_strobe = 1'b0;
        o_strobe_hiz = 1'b0;
    end

    // Controls are taken on the rising edge, so bench writes at the falling edge cannot race us
    always @(posedge i_ref_clk) begin
        kick_q <= i_kick_en;
        free_q <= i_strobe_free;
    end

    // kick in time
    // A released line flips once to the inverse and then stands still, so only the flag keeps the timer clear
    always @(negedge i_ref_clk) begin
        cnt <= (cnt >= PERIOD - 1) ? 0 : cnt + 1;
        o_strobe_hiz <= free_q;
        if ((free_q && !o_strobe_hiz) || (!free_q && kick_q && cnt == 0)) begin
            o_strobe <= ~o_strobe;
        end
    end
endmodule

// File: supervisor_watchdog_reset_test.sv
// Self-checking testbench for the supervisor watchdog and reset block
`timescale 1ns/10ps

module supervisor_watchdog_reset_test;
    localparam int RST = 20;
    localparam int WD = 50;
    localparam int KP = 10;
    logic ref_clk, sys_rst, manual_reset_n, supply_low, kick_en, strobe_free;
    logic strobe_in, strobe_hiz, sense_in, reset_n, timeout_n, warn_n;
    int n_errors = 0;
    int samples_checked = 0;

    // ----------------------------------------
    // Design, partner and clock
    // ----------------------------------------
    supervisor_watchdog_reset #(.RST_PULSE_CYC(RST), .WD_TIMEOUT_CYC(WD)) supervisor_watchdog_reset_i (
        .i_ref_clk(ref_clk), .i_sys_rst(sys_rst), .i_manual_reset_n(manual_reset_n),
        .i_supply_low(supply_low), .i_watchdog_strobe_in(strobe_in),
        .i_watchdog_strobe_hiz(strobe_hiz), .i_power_fail_sense_in(sense_in),
        .o_reset_n(reset_n), .o_watchdog_timeout_n(timeout_n), .o_power_fail_warn_n(warn_n));
    host_cpu_model #(.PERIOD(KP)) host_cpu_model_i (.i_ref_clk(ref_clk), .i_kick_en(kick_en),
        .i_strobe_free(strobe_free), .o_strobe(strobe_in), .o_strobe_hiz(strobe_hiz));

    initial begin
        ref_clk = 1'b0;
        forever #50 ref_clk = ~ref_clk;
    end

    // ----------------------------------------
    // Shared tasks
    // ----------------------------------------
    function automatic logic pick(input int w);
        return (w == 0) ? reset_n : (w == 1) ? timeout_n : warn_n;
    endfunction

    task automatic check(input logic [31:0] exp, input logic [31:0] got);
        samples_checked++;
        if (got !== exp) begin
            n_errors++;
            $display("unexpected at %0t: expected %h got %h", $time, exp, got);
        end
    endtask

    // Counts edges until the output shows v; too early or never both fail
    task automatic wait_for(input int w, input logic v, input int lo, input int hi);
        int k;
        for (k = 1; k <= hi; k++) begin
            @(negedge ref_clk);
            if (pick(w) === v) break;
        end
        if (k > hi) begin
            n_errors++;
            wrap_up();
        end else begin
            check(32'h1, 32'(k >= lo));
        end
    endtask

    task automatic hold(input int w, input logic v, input int n);
        repeat (n) begin
            @(negedge ref_clk);
            check(32'(v), 32'(pick(w)));
        end
    endtask

    task automatic wrap_up;
        $display("errors %0d, comparisons %0d", n_errors, samples_checked);
        if (n_errors == 0 && samples_checked > 0) begin
            $display("Simulation passed");
        end else begin
            $display("Simulation failed");
        end
        $finish;
    endtask

    // ----------------------------------------
    // Scenarios
    // ----------------------------------------
    task automatic t_power_up;
        wait_for(0, 1'b1, RST, RST + 3);
        check(32'h1, 32'(timeout_n));
        check(32'h1, 32'(warn_n));
    endtask

    // Strobe stands still for longer than the timeout while reset is held low
    task automatic t_manual;
        kick_en = 1'b0;
        manual_reset_n = 1'b0;
        wait_for(0, 1'b0, 1, 2);
        hold(1, 1'b1, WD + 10);
        check(32'h0, 32'(reset_n));
        manual_reset_n = 1'b1;
        wait_for(0, 1'b1, RST, RST + 3);
        wait_for(1, 1'b0, WD - 1, WD + 3);
        hold(0, 1'b1, 20);
        hold(1, 1'b0, 20);
        kick_en = 1'b1;
        wait_for(1, 1'b1, 0, KP + 3);
    endtask

    task automatic t_supply;
        supply_low = 1'b1;
        wait_for(0, 1'b0, 1, 2);
        wait_for(1, 1'b0, 0, 2);
        hold(0, 1'b0, RST + 10);
        supply_low = 1'b0;
        wait_for(1, 1'b1, 0, 2);
        hold(0, 1'b0, RST - 2);
        wait_for(0, 1'b1, 0, 5);
    endtask

    task automatic t_hiz;
        kick_en = 1'b0;
        strobe_free = 1'b1;
        hold(1, 1'b1, WD + 20);
        strobe_free = 1'b0;
        wait_for(1, 1'b0, WD - 1, WD + 4);
        strobe_free = 1'b1;
        wait_for(1, 1'b1, 0, 3);
        strobe_free = 1'b0;
        kick_en = 1'b1;
    endtask

    task automatic t_power_fail;
        sense_in = 1'b1;
        wait_for(2, 1'b0, 1, 2);
        sense_in = 1'b0;
        wait_for(2, 1'b1, 1, 2);
    endtask

    // Inputs move on the falling edge only
    initial begin
        sys_rst = 1'b1;
        manual_reset_n = 1'b1;
        supply_low = 1'b0;
        kick_en = 1'b1;
        strobe_free = 1'b0;
        sense_in = 1'b0;
        repeat (4) @(negedge ref_clk);
        sys_rst = 1'b0;
        t_power_up();
        t_manual();
        t_supply();
        t_hiz();
        t_power_fail();
        wrap_up();
    end
endmodule
